// ==== pdfc_pkg.sv ====
// Purpose: shared constants of the pixel defect and field correction stage
// Assumes: 64 x 64 sensor, 12-bit pixels, registers reached over AXI4-Lite
// Notes: coordinates and counters are full-sensor positions from start of frame
package pdfc_pkg;
   localparam int PIX_W     = 12;
   localparam int COORD_W   = 8;
   localparam int IDX_W     = 6;
   localparam int N_COLS    = 64;
   localparam int N_ROWS    = 64;
   localparam int N_DEF     = 32;
   localparam int DIDX_W    = 5;
   localparam int ACC_W     = 18;
   localparam int TOT_W     = 24;
   localparam int GAIN_W    = 16;
   localparam int OFF_W     = 13;
   localparam int GAIN_FRAC = 8;
   localparam int MEAN_SH   = 6;
   localparam int TOT_SH    = 12;
   localparam int ADDR_W    = 8;
   localparam logic [ADDR_W-1:0] A_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] A_CMD    = 8'h04;
   localparam logic [ADDR_W-1:0] A_DIDX   = 8'h08;
   localparam logic [ADDR_W-1:0] A_DCOL   = 8'h0C;
   localparam logic [ADDR_W-1:0] A_DROW   = 8'h10;
   localparam logic [ADDR_W-1:0] A_LIMIT  = 8'h14;
   localparam logic [ADDR_W-1:0] A_STATUS = 8'h18;
   localparam int B_DFIX  = 0;
   localparam int B_OFIX  = 1;
   localparam int B_GFIX  = 2;
   localparam int B_KIND  = 3;
   localparam int B_BAYER = 4;
   localparam int B_GO    = 0;
   localparam int B_CLR   = 1;
   localparam int B_BUSY  = 0;
   localparam int B_DONE  = 1;
   localparam logic CAL_FLAT = 1'h1;
   localparam logic [COORD_W-1:0] COORD_NONE = 8'hFF;
   localparam logic [GAIN_W-1:0]  GAIN_ONE   = 16'h0100;
   localparam logic [GAIN_W-1:0]  GAIN_MAX   = 16'hFFFF;
   localparam logic [PIX_W-1:0]   PIX_MAX    = 12'hFFF;
   localparam logic [31:0]        DEF_LIMIT  = 32'h00000020;
   localparam logic [1:0]         RESP_OK    = 2'h0;
   localparam logic [1:0]         RESP_DEC   = 2'h3;
   localparam logic [1:0]         FLUSH_N    = 2'h3;
   localparam logic [1:0]         BUF_N      = 2'h2;
endpackage

// ==== pdfc_top.sv ====
// Purpose: defect repair, dark offset and flat gain correction of a pixel stream
// Assumes: tuser marks first pixel of frame, tlast end of row, tfend last pixel
// Notes: output passes a two-entry buffer; pixel leaves three pixels after entry
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module pdfc_top import pdfc_pkg::*; (
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // register bus, write side
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // register bus, read side
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // raw pixels from sensor readout
   input  wire logic              s_tvalid,
   output logic                   s_tready,
   input  wire logic [PIX_W-1:0]  s_tdata,
   input  wire logic              s_tuser,
   input  wire logic              s_tlast,
   input  wire logic              s_tfend,
   // corrected pixels
   output logic                   m_tvalid,
   input  wire logic              m_tready,
   output logic [PIX_W-1:0]       m_tdata,
   output logic                   m_tuser,
   output logic                   m_tlast,
   output logic                   m_tfend
);
   typedef enum logic [3:0] {
      C_IDLE = 4'h1, C_WAIT = 4'h2, C_ACC = 4'h4, C_FIN = 4'h8
   } pdfc_cal_t;

   typedef struct packed {
      logic             v;
      logic [PIX_W-1:0] pix;
      logic [IDX_W-1:0] col;
      logic [IDX_W-1:0] row;
      logic             sof;
      logic             eol;
      logic             eof;
      logic             dfct;
   } pdfc_win_t;

   typedef struct packed {
      logic                             aw_full;
      logic                             w_full;
      logic [ADDR_W-1:0]                awa;
      logic [31:0]                      wd;
      logic [3:0]                       ws;
      logic                             bvalid;
      logic [1:0]                       bresp;
      logic                             rvalid;
      logic [1:0]                       rresp;
      logic [31:0]                      rdata;
      logic                             dfix;
      logic                             ofix;
      logic                             gfix;
      logic                             kind;
      logic                             bayer;
      logic                             done;
      logic [DIDX_W-1:0]                didx;
      logic [N_DEF-1:0][COORD_W-1:0]    dcol;
      logic [N_DEF-1:0][COORD_W-1:0]    drow;
      logic [IDX_W-1:0]                 icol;
      logic [IDX_W-1:0]                 irow;
      logic [1:0]                       flush;
      pdfc_win_t [4:0]                  w;
      logic [1:0]                       bcnt;
      logic [1:0][PIX_W+2:0]            bq;
      pdfc_cal_t                        cst;
      logic [IDX_W-1:0]                 fi;
      logic [TOT_W-1:0]                 tot;
      logic [N_COLS-1:0][ACC_W-1:0]     cacc;
      logic [N_ROWS-1:0][ACC_W-1:0]     racc;
      logic [N_COLS-1:0][OFF_W-1:0]     coff;
      logic [N_ROWS-1:0][OFF_W-1:0]     roff;
      logic [N_COLS-1:0][GAIN_W-1:0]    cgain;
      logic [N_ROWS-1:0][GAIN_W-1:0]    rgain;
   } pdfc_st_t;

   function automatic logic good_nb(input pdfc_win_t p, input logic [IDX_W-1:0] row);
      return p.v && !p.dfct && p.row == row;
   endfunction

   function automatic logic [PIX_W-1:0] avg2(input logic [PIX_W-1:0] a,
                                             input logic [PIX_W-1:0] b);
      logic [PIX_W:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[PIX_W:1];
   endfunction

   function automatic logic [PIX_W-1:0] clip(input logic signed [OFF_W:0] v);
      if (v < 0) return '0;
      if (v > $signed({2'b00, PIX_MAX})) return PIX_MAX;
      return v[PIX_W-1:0];
   endfunction

   // gain that lifts a mean d to the frame mean m, in 8.8 fixed point
   function automatic logic [GAIN_W-1:0] gain_of(input logic [PIX_W-1:0] m,
                                                 input logic [PIX_W-1:0] d);
      logic [PIX_W+GAIN_FRAC-1:0] q;
      q = {m, 8'h00} / {8'h00, d};
      if (d == '0) return GAIN_ONE;
      if (q > GAIN_MAX) return GAIN_MAX;
      return q[GAIN_W-1:0];
   endfunction

   pdfc_st_t                       st_reg;
   pdfc_st_t                       st_next;
   pdfc_win_t                      c;
   pdfc_win_t                      lw;
   pdfc_win_t                      rw;
   logic                           room;
   logic                           s_ready;
   logic                           accept;
   logic                           adv;
   logic                           push;
   logic                           take;
   logic                           lok;
   logic                           rok;
   logic                           hit;
   logic [IDX_W-1:0]               ncol;
   logic [IDX_W-1:0]               nrow;
   logic [PIX_W-1:0]               fixp;
   logic signed [OFF_W:0]          diff;
   logic [PIX_W-1:0]               dpos;
   logic [PIX_W-1:0]               fld;
   logic [PIX_W-1:0]               outp;
   logic [PIX_W-1:0]               smp;
   logic [PIX_W-1:0]               cm;
   logic [PIX_W-1:0]               rm;
   logic [PIX_W-1:0]               gm;
   logic [2*GAIN_W-1:0]            gg;
   logic [2*GAIN_W+PIX_W-1:0]      pr;

   always_comb begin
      st_next = st_reg;
      c = st_reg.w[2];
      room = st_reg.bcnt != BUF_N;
      s_ready = room && st_reg.flush == 2'h0;
      accept = s_tvalid && s_ready;
      adv = accept || (room && st_reg.flush != 2'h0);
      push = adv && c.v;
      // mono falls back one pixel further out when the next neighbour is also listed
      if (st_reg.bayer) begin
         lw = st_reg.w[4];
         rw = st_reg.w[0];
      end else begin
         lw = (st_reg.w[3].dfct && st_reg.w[4].v) ? st_reg.w[4] : st_reg.w[3];
         rw = (st_reg.w[1].dfct && st_reg.w[0].v) ? st_reg.w[0] : st_reg.w[1];
      end
      lok = good_nb(lw, c.row);
      rok = good_nb(rw, c.row);
      fixp = c.pix;
      if (st_reg.dfix && c.dfct) begin
         if (lok && rok) begin
            fixp = avg2(lw.pix, rw.pix);
         end else if (lok) begin
            fixp = lw.pix;
         end else if (rok) begin
            fixp = rw.pix;
         end
      end
      // field correction works on the repaired value
      diff = $signed({2'b00, fixp}) - $signed({st_reg.coff[c.col][OFF_W-1], st_reg.coff[c.col]})
             - $signed({st_reg.roff[c.row][OFF_W-1], st_reg.roff[c.row]});
      dpos = clip(diff);
      fld = st_reg.ofix ? dpos : fixp;
      gg = st_reg.cgain[c.col] * st_reg.rgain[c.row];
      pr = (2*GAIN_W+PIX_W)'(gg) * (2*GAIN_W+PIX_W)'(fld);
      outp = fld;
      if (st_reg.gfix) begin
         outp = ((pr >> (2*GAIN_FRAC)) > PIX_MAX) ? PIX_MAX : pr[2*GAIN_FRAC +: PIX_W];
      end
      // positions count from the first pixel of the full frame
      ncol = s_tuser ? '0 : st_reg.icol;
      nrow = s_tuser ? '0 : st_reg.irow;
      hit = 1'b0;
      for (int i = 0; i < N_DEF; i++) begin
         if (st_reg.dcol[i] != COORD_NONE && st_reg.drow[i] != COORD_NONE
             && st_reg.dcol[i] == {2'b00, ncol} && st_reg.drow[i] == {2'b00, nrow}) begin
            hit = 1'b1;
         end
      end
      // window: w[0] newest, w[2] the pixel leaving; frame end flushes three slots
      if (adv) begin
         st_next.w[4:1] = st_reg.w[3:0];
         st_next.w[0] = '0;
         if (accept) begin
            st_next.w[0] = {1'b1, s_tdata, ncol, nrow, s_tuser, s_tlast, s_tfend, hit};
            st_next.icol = ncol + 1'b1;
            st_next.irow = nrow;
            if (s_tfend) begin
               st_next.icol = '0;
               st_next.irow = '0;
               st_next.flush = FLUSH_N;
            end else if (s_tlast) begin
               st_next.icol = '0;
               st_next.irow = nrow + 1'b1;
            end
         end else begin
            st_next.flush = st_reg.flush - 2'h1;
         end
      end
      // output buffer; a stalled receiver holds the window through room
      if (st_reg.bcnt != 2'h0 && m_tready) begin
         st_next.bq[0] = st_reg.bq[1];
         st_next.bcnt = st_reg.bcnt - 2'h1;
      end
      if (push) begin
         st_next.bq[st_next.bcnt[0]] = {outp, c.sof, c.eol, c.eof};
         st_next.bcnt = st_next.bcnt + 2'h1;
      end
      // calibration: whole-frame sums per row and column, coefficients after the frame
      smp = (st_reg.kind == CAL_FLAT) ? dpos : fixp;
      take = push && ((st_reg.cst == C_WAIT && c.sof) || st_reg.cst == C_ACC);
      if (take) begin
         st_next.cacc[c.col] = st_reg.cacc[c.col] + ACC_W'(smp);
         st_next.racc[c.row] = st_reg.racc[c.row] + ACC_W'(smp);
         st_next.tot = st_reg.tot + TOT_W'(smp);
         st_next.cst = c.eof ? C_FIN : C_ACC;
      end
      cm = PIX_W'(st_reg.cacc[st_reg.fi] >> MEAN_SH);
      rm = PIX_W'(st_reg.racc[st_reg.fi] >> MEAN_SH);
      gm = PIX_W'(st_reg.tot >> TOT_SH);
      case (st_reg.cst)
         C_FIN: begin
            if (st_reg.kind == CAL_FLAT) begin
               st_next.cgain[st_reg.fi] = gain_of(gm, cm);
               st_next.rgain[st_reg.fi] = gain_of(gm, rm);
            end else begin
               // the row term keeps only the row's deviation from the frame mean
               st_next.coff[st_reg.fi] = {1'b0, cm};
               st_next.roff[st_reg.fi] = {1'b0, rm} - {1'b0, gm};
            end
            st_next.fi = st_reg.fi + 1'b1;
            if (st_reg.fi == IDX_W'(N_COLS - 1)) begin
               st_next.cst = C_IDLE;
               st_next.done = 1'b1;
            end
         end
         default: begin
         end
      endcase
      // register bus
      s_axi_awready = !st_reg.aw_full && !st_reg.bvalid;
      s_axi_wready = !st_reg.w_full && !st_reg.bvalid;
      s_axi_arready = !st_reg.rvalid;
      if (st_reg.bvalid && s_axi_bready) st_next.bvalid = 1'b0;
      if (st_reg.rvalid && s_axi_rready) st_next.rvalid = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         st_next.aw_full = 1'b1;
         st_next.awa = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_next.w_full = 1'b1;
         st_next.wd = s_axi_wdata;
         st_next.ws = s_axi_wstrb;
      end
      if (st_reg.aw_full && st_reg.w_full) begin
         st_next.aw_full = 1'b0;
         st_next.w_full = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = RESP_OK;
         if (st_reg.awa == A_CTRL) begin
            if (st_reg.ws[0]) begin
               st_next.dfix = st_reg.wd[B_DFIX];
               st_next.ofix = st_reg.wd[B_OFIX];
               st_next.gfix = st_reg.wd[B_GFIX];
               st_next.kind = st_reg.wd[B_KIND];
               st_next.bayer = st_reg.wd[B_BAYER];
            end
         end else if (st_reg.awa == A_CMD) begin
            if (st_reg.ws[0] && st_reg.wd[B_GO]) begin
               st_next.cst = C_WAIT;
               st_next.done = 1'b0;
               st_next.fi = '0;
               st_next.tot = '0;
               st_next.cacc = '0;
               st_next.racc = '0;
            end
            if (st_reg.ws[0] && st_reg.wd[B_CLR]) begin
               st_next.dcol[st_reg.didx] = COORD_NONE;
               st_next.drow[st_reg.didx] = COORD_NONE;
            end
         end else if (st_reg.awa == A_DIDX) begin
            if (st_reg.ws[0]) st_next.didx = st_reg.wd[DIDX_W-1:0];
         end else if (st_reg.awa == A_DCOL) begin
            if (st_reg.ws[0]) st_next.dcol[st_reg.didx] = st_reg.wd[COORD_W-1:0];
         end else if (st_reg.awa == A_DROW) begin
            if (st_reg.ws[0]) st_next.drow[st_reg.didx] = st_reg.wd[COORD_W-1:0];
         end else if (st_reg.awa != A_LIMIT && st_reg.awa != A_STATUS) begin
            st_next.bresp = RESP_DEC;
         end
      end
      if (s_axi_arvalid && s_axi_arready) begin
         st_next.rvalid = 1'b1;
         st_next.rresp = RESP_OK;
         st_next.rdata = '0;
         if (s_axi_araddr == A_CTRL) begin
            st_next.rdata[B_DFIX] = st_reg.dfix;
            st_next.rdata[B_OFIX] = st_reg.ofix;
            st_next.rdata[B_GFIX] = st_reg.gfix;
            st_next.rdata[B_KIND] = st_reg.kind;
            st_next.rdata[B_BAYER] = st_reg.bayer;
         end else if (s_axi_araddr == A_CMD) begin
            st_next.rdata = '0;
         end else if (s_axi_araddr == A_DIDX) begin
            st_next.rdata[DIDX_W-1:0] = st_reg.didx;
         end else if (s_axi_araddr == A_DCOL) begin
            st_next.rdata = 32'($signed(st_reg.dcol[st_reg.didx]));
         end else if (s_axi_araddr == A_DROW) begin
            st_next.rdata = 32'($signed(st_reg.drow[st_reg.didx]));
         end else if (s_axi_araddr == A_LIMIT) begin
            st_next.rdata = DEF_LIMIT;
         end else if (s_axi_araddr == A_STATUS) begin
            st_next.rdata[B_BUSY] = st_reg.cst != C_IDLE;
            st_next.rdata[B_DONE] = st_reg.done;
         end else begin
            st_next.rresp = RESP_DEC;
         end
      end
      if (!aresetn) begin
         st_next = '0;
         st_next.cst = C_IDLE;
         for (int i = 0; i < N_DEF; i++) begin
            st_next.dcol[i] = COORD_NONE;
            st_next.drow[i] = COORD_NONE;
         end
         for (int i = 0; i < N_COLS; i++) begin
            st_next.cgain[i] = GAIN_ONE;
            st_next.rgain[i] = GAIN_ONE;
         end
      end
   end

   always_ff @(posedge aclk) begin
      st_reg <= st_next;
   end

   assign s_tready = s_ready;
   assign m_tvalid = st_reg.bcnt != 2'h0;
   assign {m_tdata, m_tuser, m_tlast, m_tfend} = st_reg.bq[0];
   assign s_axi_bvalid = st_reg.bvalid;
   assign s_axi_bresp = st_reg.bresp;
   assign s_axi_rvalid = st_reg.rvalid;
   assign s_axi_rresp = st_reg.rresp;
   assign s_axi_rdata = st_reg.rdata;

   sequence s_cmd_wr;
      st_reg.aw_full && st_reg.w_full && st_reg.awa == A_CMD && st_reg.ws[0];
   endsequence

   AST_BYPASS_ALL: assert property (@(posedge aclk) disable iff (!aresetn)
      push && !st_reg.dfix && !st_reg.ofix && !st_reg.gfix |-> outp == c.pix)
      else $error("pixel altered with all corrections off");
   AST_LIMIT_READ: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == A_LIMIT
      |=> s_axi_rvalid && s_axi_rdata == DEF_LIMIT) else $error("limit read wrong");
   AST_CLEAR_ENTRY: assert property (@(posedge aclk) disable iff (!aresetn)
      s_cmd_wr ##0 st_reg.wd[B_CLR] |=> st_reg.dcol[$past(st_reg.didx)] == COORD_NONE)
      else $error("entry not cleared");
   AST_MONO_AVG: assert property (@(posedge aclk) disable iff (!aresetn)
      push && st_reg.dfix && !st_reg.bayer && c.dfct && good_nb(st_reg.w[3], c.row)
      && good_nb(st_reg.w[1], c.row) |-> fixp == avg2(st_reg.w[3].pix, st_reg.w[1].pix))
      else $error("mono repair wrong");
   AST_BAYER_AVG: assert property (@(posedge aclk) disable iff (!aresetn)
      push && st_reg.dfix && st_reg.bayer && c.dfct && good_nb(st_reg.w[4], c.row)
      && good_nb(st_reg.w[0], c.row) |-> fixp == avg2(st_reg.w[4].pix, st_reg.w[0].pix))
      else $error("bayer repair wrong");
   AST_CAL_ARM: assert property (@(posedge aclk) disable iff (!aresetn)
      s_cmd_wr ##0 st_reg.wd[B_GO] |=> st_reg.cst == C_WAIT ##1 st_reg.cst != C_IDLE)
      else $error("calibration did not arm");
   AST_UNUSED_SKIP: assert property (@(posedge aclk) disable iff (!aresetn)
      accept && st_reg.dcol == {N_DEF{COORD_NONE}} |=> !st_reg.w[0].dfct)
      else $error("unused entry matched");
   AST_HOLD_COEF: assert property (@(posedge aclk) disable iff (!aresetn)
      st_reg.cst == C_ACC |=> $stable(st_reg.coff) && $stable(st_reg.cgain))
      else $error("coefficients moved mid frame");
endmodule
`default_nettype wire

// ==== pdfc_sensor.sv ====
// Purpose: sensor readout and downstream sink model for the correction stage
// Assumes: 64 x 64 frames, each pixel holds its column number squared; with dead set, pixel 12'h14A holds 12'hFFF
// Notes: idle data toggles every cycle so a stale pixel never passes for a live one
`timescale 1ns/10ps
`default_nettype none
module pdfc_sensor import pdfc_pkg::*; (
   // bench control
   input  wire logic             aclk,
   input  wire logic             go,
   input  wire logic             dead,
   input  wire logic             stall,
   // pixel source
   input  wire logic             s_tready,
   output logic                  s_tvalid,
   output logic [PIX_W-1:0]      s_tdata,
   output logic                  s_tuser,
   output logic                  s_tlast,
   output logic                  s_tfend,
   // pixel sink
   output logic                  m_tready
);
   logic        busy = 1'b0;
   logic [1:0]  ph   = 2'h0;
   logic [11:0] pos  = 12'h000;
   initial begin
      s_tvalid = 1'b0;
      s_tdata = 12'h000;
      s_tuser = 1'b0;
      s_tlast = 1'b0;
      s_tfend = 1'b0;
      m_tready = 1'b1;
   end
   function automatic logic [11:0] pix(input logic [11:0] p);
      logic [11:0] x;
      x = {6'h00, p[5:0]};
      pix = (dead && p == 12'h14A) ? 12'hFFF : x * x;
   endfunction
   task automatic put(input logic [11:0] p);
      pos <= p;
      s_tdata <= pix(p);
      s_tuser <= (p == 12'h000);
      s_tlast <= (p[5:0] == 6'h3F);
      s_tfend <= (p == 12'hFFF);
   endtask
   always @(posedge aclk) begin
      ph <= ph + 2'h1;
      // a slow sink takes one pixel in four, enough to fill the buffer
      m_tready <= !stall || ph == 2'h0;
      if (!busy) begin
         s_tdata <= ~s_tdata;
         if (go) begin
            busy <= 1'b1;
            s_tvalid <= 1'b1;
            put(12'h000);
         end
      end else if (s_tready) begin
         if (pos == 12'hFFF) begin
            busy <= 1'b0;
            s_tvalid <= 1'b0;
            s_tdata <= ~s_tdata;
         end else put(pos + 12'h001);
      end
   end
endmodule
`default_nettype wire

// ==== pixel_defect_field_correction_test.sv ====
// Purpose: register and pixel stream checks of the correction stage
// Assumes: sensor model streams frames; dead pixel at column 10, row 5; column 11 listed too
// Notes: only the first frame stalls the sink; run is cut at 90000 cycles
`timescale 1ns/10ps
`default_nettype none
module pixel_defect_field_correction_test import pdfc_pkg::*;;
   logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, go = 1'b0, dead = 1'b0, stall = 1'b0;
   logic        full_seen = 1'b0, u0, awready, wready, bvalid, arready, rvalid, m_tlast, m_tfend;
   logic        s_tvalid, s_tready, s_tuser, s_tlast, s_tfend, m_tvalid, m_tready, m_tuser;
   logic [1:0]  bresp, rresp;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [11:0] s_tdata, m_tdata, img [4096];
   logic [31:0] wdata = 32'h00000000, rdata, rdat;
   int          ocnt = 0, cyc = 0, errors = 0, n_compared = 0, sbad = 0;
   always #20 aclk = ~aclk;
   pdfc_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_tvalid(s_tvalid), .s_tready(s_tready), .s_tdata(s_tdata), .s_tuser(s_tuser),
      .s_tlast(s_tlast), .s_tfend(s_tfend), .m_tvalid(m_tvalid), .m_tready(m_tready),
      .m_tdata(m_tdata), .m_tuser(m_tuser), .m_tlast(m_tlast), .m_tfend(m_tfend));
   pdfc_sensor SNS (.aclk(aclk), .go(go), .dead(dead), .stall(stall), .s_tready(s_tready),
      .s_tvalid(s_tvalid), .s_tdata(s_tdata), .s_tuser(s_tuser), .s_tlast(s_tlast),
      .s_tfend(s_tfend), .m_tready(m_tready));
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (m_tvalid && m_tready) begin
         img[ocnt] <= m_tdata;
         ocnt <= ocnt + 1;
         if (ocnt == 0) u0 <= m_tuser;
         // sidebands must travel with their pixel through the window
         if ({m_tuser, m_tlast, m_tfend} !== {ocnt == 0, ocnt % 64 == 63, ocnt == 4095})
            sbad <= sbad + 1;
      end
      if (m_tvalid && !m_tready && !s_tready) full_seen <= 1'b1;
      if (cyc == 90000) begin
         errors++;
         give_verdict();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OK);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk(32'(bresp), 32'(er));
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] er = RESP_OK);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      rdat = rdata;
      chk(32'(rresp), 32'(er));
   endtask
   task automatic frame(input logic dd, input logic ss);
      @(posedge aclk);
      ocnt <= 0;
      sbad <= 0;
      dead <= dd;
      stall <= ss;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      while (ocnt != 4096) @(posedge aclk);
   endtask
   // d: 0 raw, 1 mono, 2 bayer, 3 only column 11 listed; off: column offsets removed
   task automatic ckf(input int d, input bit off);
      int v;
      int x;
      chk(32'(u0), 32'h00000001);
      chk(sbad, 32'h00000000);
      for (int p = 0; p < 4096; p++) begin
         x = p % 64;
         v = x * x;
         if (p == 330) v = (d == 0 || d == 3) ? 4095 : d == 1 ? 112 : 104;
         if (p == 331) v = d == 1 ? 112 : d == 2 ? 125 : d == 3 ? 2119 : v;
         if (off) v = v > x * x ? v - x * x : 0;
         chk(32'(img[p]), v);
      end
      $display("frame check done");
   endtask
   task automatic cal(input logic [31:0] c);
      wr(A_CTRL, c);
      wr(A_CMD, 32'h00000001);
      frame(1'b0, 1'b0);
      do rd(A_STATUS); while (!rdat[B_DONE]);
      chk(32'(rdat[B_BUSY]), 32'h00000000);
      $display("calibration done");
   endtask
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(A_LIMIT);
      chk(rdat, DEF_LIMIT);
      wr(A_LIMIT, 32'h00000001);
      rd(A_LIMIT);
      chk(rdat, DEF_LIMIT);
      rd(8'h1C, RESP_DEC);
      wr(8'h1C, 32'h000000FF, RESP_DEC);
      wr(A_DIDX, 32'h0000001F);
      rd(A_DCOL);
      chk(rdat, 32'hFFFFFFFF);
      wr(A_DCOL, 32'h0000000A);
      wr(A_DROW, 32'h00000005);
      rd(A_DROW);
      chk(rdat, 32'h00000005);
      wr(A_DIDX, 32'h0000001E);
      wr(A_DCOL, 32'h0000000B);
      wr(A_DROW, 32'h00000005);
      wr(A_DIDX, 32'h0000001F);
      $display("register test done");
      frame(1'b1, 1'b1);
      ckf(0, 0);
      chk(32'(full_seen), 32'h00000001);
      wr(A_CTRL, 32'h00000001);
      frame(1'b1, 1'b0);
      ckf(1, 0);
      wr(A_CTRL, 32'h00000011);
      frame(1'b1, 1'b0);
      ckf(2, 0);
      cal(32'h00000000);
      wr(A_CTRL, 32'h00000003);
      frame(1'b1, 1'b0);
      ckf(1, 1);
      cal(32'h0000000B);
      wr(A_CTRL, 32'h00000007);
      frame(1'b1, 1'b0);
      ckf(1, 1);
      wr(A_CMD, 32'h00000002);
      rd(A_DCOL);
      chk(rdat, 32'hFFFFFFFF);
      wr(A_CTRL, 32'h00000001);
      frame(1'b1, 1'b0);
      ckf(3, 0);
      give_verdict();
   end
endmodule
`default_nettype wire
